// ==== logic/spio_pkg.sv ====
// Package for the shared parallel I/O port: widths, reset values and masks.
// Assumes a single synchronous clock domain and plain register ports.
`default_nettype none
package spio_pkg;
    localparam int SPIO_W = 16;
    typedef logic [SPIO_W-1:0] spio_word_t;
    // Register selects for the software access port.
    typedef enum logic [2:0] {
        SPIO_SEL_DIR,
        SPIO_SEL_LAT,
        SPIO_SEL_PIN,
        SPIO_SEL_ODC,
        SPIO_SEL_ANS
    } spio_sel_e;
    localparam spio_word_t SPIO_DIR_RST = 16'hFFFF;
    localparam spio_word_t SPIO_LAT_RST = 16'h0000;
    localparam spio_word_t SPIO_ODC_RST = 16'h0000;
    localparam spio_word_t SPIO_ANS_RST = 16'hFFFF;
    localparam spio_word_t SPIO_IMPL_MASK_DEF = 16'hFFFF;
    localparam spio_word_t SPIO_ANA_MASK_DEF = 16'h000F;
    localparam int SPIO_SYNC_STAGES = 2;
endpackage : spio_pkg
`default_nettype wire

// ==== logic/spio_sync.sv ====
// Two-flop synchroniser for the pin input levels.
// Assumes the pins are asynchronous to clk.
`default_nettype none
module spio_sync
    import spio_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Data.
    input wire spio_pkg::spio_word_t async_in,
    output var spio_pkg::spio_word_t sync_out
);
    spio_word_t meta_r;
    spio_word_t sync_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : spio_sync
`default_nettype wire

// ==== logic/spio_pin_mux.sv ====
// Per-pin output multiplexer between the port bit and a peripheral.
// Assumes all inputs are synchronous to clk; output is combinational.
`default_nettype none
module spio_pin_mux (
    // Peripheral side.
    input wire logic per_en,
    input wire logic per_drive,
    input wire logic per_out,
    // Port side.
    input wire logic port_dir,
    input wire logic port_lat,
    input wire logic port_odc,
    input wire logic port_ana,
    // Pin drive.
    output logic pad_out,
    output logic pad_oe
);
    logic per_owns;
    logic port_drives;

    // An enabled peripheral that drives takes the pin. [RULE1] [RULE4] [RULE5]
    assign per_owns = per_en && per_drive;
    // Direction 0 is an output, and analog use disables the digital driver. [RULE6] [RULE13]
    assign port_drives = !port_dir && !port_ana;

    // Data and enable each chosen from peripheral or port. [RULE2]
    always_comb begin
        if (per_owns) begin
            pad_out = per_out;
            pad_oe = 1'b1;
        end else begin
            pad_out = port_lat;
            pad_oe = port_drives;
        end
        // Open drain only pulls low. [RULE12]
        if (port_odc && pad_out) begin
            pad_oe = 1'b0;
        end
        if (port_odc) begin
            pad_out = 1'b0;
        end
    end
endmodule : spio_pin_mux
`default_nettype wire

// ==== logic/spio_port.sv ====
// Shared parallel I/O port: registers, pin read path and peripheral muxing.
// Assumes software uses the write strobe and select ports synchronous to clk;
// pins are asynchronous and are synchronised before use.
`default_nettype none
//
// Contract
// RULE1: An enabled, driving peripheral takes precedence over the port bit.
// RULE2: Pin data and enable come from multiplexers choosing peripheral or port.
// RULE3: Port output never loops back into the sharing peripheral's input.
// RULE4: Driving peripheral disables the port driver; pin stays readable.
// RULE5: Enabled but idle peripheral lets the port drive the pin.
// RULE6: Direction 1 makes an input, 0 an output.
// RULE7: Reset sets all direction bits, so all pins are inputs.
// RULE8: Latch read returns latch contents; latch write updates latch.
// RULE9: Pin-value read returns pin levels; its write updates the latch.
// RULE10: Unimplemented bits read zero from latch, direction and pin value.
// RULE11: Software waits one cycle between write or direction change and read.
// RULE12: Per-bit open drain drives low only and floats for high.
// RULE13: Analog-select with direction chooses analog or digital pin use.
// RULE14: Analog inputs read zero in the pin-value register.
// RULE15: Software waits one cycle after making a digital input before reading.
// RULE16: Sixteen-bit port with a variant mask tying absent bits to zero.
module spio_port
    import spio_pkg::*;
#(
    parameter spio_pkg::spio_word_t IMPL_MASK = spio_pkg::SPIO_IMPL_MASK_DEF,
    parameter spio_pkg::spio_word_t ANA_MASK = spio_pkg::SPIO_ANA_MASK_DEF
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Software access.
    input wire logic reg_wr,
    input wire spio_pkg::spio_sel_e reg_sel,
    input wire spio_pkg::spio_word_t reg_wdata,
    output var spio_pkg::spio_word_t reg_rdata,
    // Peripheral output side.
    input wire spio_pkg::spio_word_t per_en,
    input wire spio_pkg::spio_word_t per_drive,
    input wire spio_pkg::spio_word_t per_out,
    // Peripheral input side.
    output var spio_pkg::spio_word_t per_in,
    // Pins.
    input wire spio_pkg::spio_word_t pad_in,
    output var spio_pkg::spio_word_t pad_out,
    output var spio_pkg::spio_word_t pad_oe,
    // Status.
    output var spio_pkg::spio_word_t pin_direction_reg,
    output var spio_pkg::spio_word_t output_latch_reg
);
    import spio_pkg::*;

    spio_word_t dir_r;
    spio_word_t lat_r;
    spio_word_t odc_r;
    spio_word_t ans_r;
    spio_word_t pin_sync;
    spio_word_t mux_out;
    spio_word_t mux_oe;
    spio_word_t pin_view;
    spio_word_t pad_out_r;
    spio_word_t pad_oe_r;
    spio_word_t per_in_r;
    spio_word_t rdata_r;

    // Returns the value a pin-value read shows for the given state.
    function automatic spio_word_t pin_read(spio_word_t pins, spio_word_t ans,
                                            spio_word_t dir);
        // Analog inputs read low; absent bits read zero. [RULE14] [RULE10]
        return pins & ~(ans & dir & ANA_MASK) & IMPL_MASK;
    endfunction : pin_read

    spio_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pad_in),
        .sync_out(pin_sync)
    );

    // Direction register; reset makes every pin an input. [RULE7] [RULE6]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_r <= SPIO_DIR_RST & IMPL_MASK;
        end else if (reg_wr && reg_sel == SPIO_SEL_DIR) begin
            dir_r <= reg_wdata & IMPL_MASK;
        end
    end

    // Latch is written through either the latch or the pin-value select. [RULE8] [RULE9]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lat_r <= SPIO_LAT_RST;
        end else if (reg_wr && (reg_sel == SPIO_SEL_LAT || reg_sel == SPIO_SEL_PIN)) begin
            lat_r <= reg_wdata & IMPL_MASK; // [RULE16]
        end
    end

    // Open-drain control. [RULE12]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            odc_r <= SPIO_ODC_RST;
        end else if (reg_wr && reg_sel == SPIO_SEL_ODC) begin
            odc_r <= reg_wdata & IMPL_MASK;
        end
    end

    // Analog select exists only on analog-capable bits. [RULE13]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ans_r <= SPIO_ANS_RST & ANA_MASK & IMPL_MASK;
        end else if (reg_wr && reg_sel == SPIO_SEL_ANS) begin
            ans_r <= reg_wdata & ANA_MASK & IMPL_MASK;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SPIO_W; gi++) begin : g_pin
            if (IMPL_MASK[gi]) begin : g_impl
                spio_pin_mux u_mux (
                    .per_en(per_en[gi]),
                    .per_drive(per_drive[gi]),
                    .per_out(per_out[gi]),
                    .port_dir(dir_r[gi]),
                    .port_lat(lat_r[gi]),
                    .port_odc(odc_r[gi]),
                    .port_ana(ans_r[gi]),
                    .pad_out(mux_out[gi]),
                    .pad_oe(mux_oe[gi])
                );
            end else begin : g_absent
                assign mux_out[gi] = 1'b0; // [RULE16]
                assign mux_oe[gi] = 1'b0;
            end
        end
    endgenerate

    assign pin_view = pin_read(pin_sync, ans_r, dir_r);

    // Registered pin drive. [RULE2]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
        end else begin
            pad_out_r <= mux_out;
            pad_oe_r <= mux_oe;
        end
    end

    // Bits where the port itself, not a peripheral, currently drives the pin.
    function automatic spio_word_t port_driven(spio_word_t oe, spio_word_t en,
                                               spio_word_t drv);
        return oe & ~(en & drv);
    endfunction : port_driven

    // Peripheral sees the pin only where the port is not driving it. [RULE3]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            per_in_r <= '0;
        end else begin
            per_in_r <= pin_sync & ~port_driven(pad_oe_r, per_en, per_drive) & IMPL_MASK;
        end
    end

    // Read data register. [RULE8] [RULE9] [RULE10]
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else begin
            unique case (reg_sel)
                SPIO_SEL_DIR: rdata_r <= dir_r;
                SPIO_SEL_LAT: rdata_r <= lat_r;
                SPIO_SEL_PIN: rdata_r <= pin_view;
                SPIO_SEL_ODC: rdata_r <= odc_r;
                SPIO_SEL_ANS: rdata_r <= ans_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign per_in = per_in_r;
    assign pad_out = pad_out_r;
    assign pad_oe = pad_oe_r;
    assign pin_direction_reg = dir_r;
    assign output_latch_reg = lat_r;

    // Assertions.
    a_reset_inputs: assert property (@(posedge clk) // [RULE7]
        sys_rst |=> dir_r == (SPIO_DIR_RST & IMPL_MASK))
        else $error("Direction not all inputs after reset.");

    a_periph_owns: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
        ((per_en & per_drive & IMPL_MASK) != '0) |=>
        ((pad_oe & $past(per_en & per_drive & IMPL_MASK & ~odc_r))
         == $past(per_en & per_drive & IMPL_MASK & ~odc_r)))
        else $error("Driving peripheral did not own its pin.");

    a_port_output: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
        1'b1 |=> ((pad_oe & $past(~(per_en & per_drive) & ~dir_r & ~ans_r & ~odc_r & IMPL_MASK))
                  == $past(~(per_en & per_drive) & ~dir_r & ~ans_r & ~odc_r & IMPL_MASK)))
        else $error("Port output bit did not drive.");

    a_input_float: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        1'b1 |=> ((pad_oe & $past(~(per_en & per_drive) & dir_r)) == '0))
        else $error("Input pin was driven by the port.");

    a_open_drain: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        1'b1 |=> ((pad_out & $past(odc_r)) == '0)
            && ((pad_oe & $past(odc_r & lat_r & ~(per_en & per_drive))) == '0))
        else $error("Open-drain pin drove high.");

    a_pin_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
        reg_wr && reg_sel == SPIO_SEL_PIN |=> lat_r == ($past(reg_wdata) & IMPL_MASK))
        else $error("Pin-value write did not reach latch.");

    a_lat_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
        !reg_wr && reg_sel == SPIO_SEL_LAT ##1 !reg_wr |-> reg_rdata == lat_r)
        else $error("Latch read did not return latch.");

    a_analog_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
        reg_sel == SPIO_SEL_PIN |=> (reg_rdata & $past(ans_r & dir_r)) == '0)
        else $error("Analog input read nonzero.");

    a_absent_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
        (reg_rdata & ~IMPL_MASK) == '0 && (pad_oe & ~IMPL_MASK) == '0)
        else $error("Unimplemented bit read nonzero.");

    a_no_loop: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        1'b1 |=> (per_in & $past(pad_oe_r & ~(per_en & per_drive))) == '0)
        else $error("Port output looped into peripheral.");

    // Register write steps for the write checks; s_dir_write also starts the direction read-back check.
    sequence s_lat_write;
        reg_wr && (reg_sel == SPIO_SEL_LAT || reg_sel == SPIO_SEL_PIN);
    endsequence : s_lat_write

    sequence s_dir_write;
        reg_wr && reg_sel == SPIO_SEL_DIR;
    endsequence : s_dir_write

    sequence s_odc_write;
        reg_wr && reg_sel == SPIO_SEL_ODC;
    endsequence : s_odc_write

    sequence s_ans_write;
        reg_wr && reg_sel == SPIO_SEL_ANS;
    endsequence : s_ans_write

    a_lat_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
        s_lat_write |=> lat_r == ($past(reg_wdata) & IMPL_MASK))
        else $error("Latch write did not land.");

    a_dir_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        s_dir_write |=> dir_r == ($past(reg_wdata) & IMPL_MASK))
        else $error("Direction write did not land.");

    a_odc_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        s_odc_write |=> odc_r == ($past(reg_wdata) & IMPL_MASK))
        else $error("Open-drain write did not land.");

    a_ans_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        s_ans_write |=> ans_r == ($past(reg_wdata) & ANA_MASK & IMPL_MASK))
        else $error("Analog-select write did not land.");

    a_dir_readback: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        s_dir_write ##1 (reg_sel == SPIO_SEL_DIR)
        |=> reg_rdata == ($past(reg_wdata, 2) & IMPL_MASK))
        else $error("Direction read-back did not show the write.");

    a_periph_data: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
        1'b1 |=> ((pad_out ^ $past(per_out))
                  & $past(per_en & per_drive & ~odc_r & IMPL_MASK)) == '0)
        else $error("Pin data did not follow the driving peripheral.");

    a_port_data: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
        1'b1 |=> ((pad_out ^ $past(lat_r))
                  & $past(~(per_en & per_drive) & ~odc_r & IMPL_MASK)) == '0)
        else $error("Pin data did not follow the latch.");

    a_analog_block: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        1'b1 |=> (pad_oe & $past(ans_r & ~(per_en & per_drive))) == '0)
        else $error("Analog pin was driven by the port.");

    a_absent_out: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
        (pad_out & ~IMPL_MASK) == '0 && (per_in & ~IMPL_MASK) == '0)
        else $error("Unimplemented bit drove a nonzero output.");

    a_per_in_pass: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
        1'b1 |=> ((per_in ^ $past(pin_sync))
                  & $past(per_en & per_drive & IMPL_MASK)) == '0)
        else $error("Peripheral lost sight of its own pin.");

    a_pin_readable: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
        reg_sel == SPIO_SEL_PIN |=> ((reg_rdata ^ $past(pin_sync))
                  & $past(per_en & per_drive & ~ans_r & IMPL_MASK)) == '0)
        else $error("Peripheral-driven pin did not read back.");

    a_out_reset: assert property (@(posedge clk) // [RULE7]
        sys_rst |=> reg_rdata == '0 && pad_oe == '0 && per_in == '0)
        else $error("Outputs not cleared by reset.");
endmodule : spio_port
`default_nettype wire

// ==== dv/spio_pads.sv ====
// Pin model for the shared parallel I/O port: outside drivers and pull-ups.
// Assumes the port's pad_out and pad_oe; a driving port wins over the outside.
`default_nettype none
module spio_pads
    import spio_pkg::*;
(
    // From the port.
    input wire spio_pkg::spio_word_t pad_out,
    input wire spio_pkg::spio_word_t pad_oe,
    // Outside drivers.
    input wire spio_pkg::spio_word_t ext_val,
    input wire spio_pkg::spio_word_t ext_oe,
    // To the port.
    output var spio_pkg::spio_word_t pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven pins, released open-drain pins among them, rise through the pull-up.
    always_comb begin
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) | (~pad_oe & ~ext_oe);
    end
endmodule : spio_pads
`default_nettype wire

// ==== dv/tb.sv ====
// Testbench for the shared parallel I/O port with a scoreboard of expected outputs.
// Assumes the pin model spio_pads and the port design under logic/.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spio_pkg::*;
    localparam spio_word_t IMPL = 16'h7F9F;
    localparam spio_word_t ANA = 16'h000F;
    typedef struct {int at; logic [2:0] k; spio_word_t e;} spio_chk_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    spio_sel_e reg_sel = SPIO_SEL_DIR;
    spio_word_t reg_wdata = 16'h0000;
    spio_word_t per_en = 16'h0000;
    spio_word_t per_drive = 16'h0000;
    spio_word_t per_out = 16'h0000;
    spio_word_t ext_val = 16'h0000;
    spio_word_t ext_oe = 16'h0000;
    spio_word_t reg_rdata, per_in, pad_in, pad_out, pad_oe, dir_o, lat_o, g;
    spio_word_t m_dir, m_lat, m_odc, m_ans, own, dat, e_oe, e_out, e_lvl, e_pdrv;
    spio_chk_s q[$];
    spio_chk_s c;
    int cyc = 0;
    int miscompares = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h235AB307;
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    spio_port #(.IMPL_MASK(IMPL), .ANA_MASK(ANA)) i_spio_port (.clk(clk), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .per_en(per_en), .per_drive(per_drive), .per_out(per_out), .per_in(per_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pin_direction_reg(dir_o), .output_latch_reg(lat_o));
    spio_pads i_spio_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
        .ext_oe(ext_oe), .pad_in(pad_in));
    // Expected pin behaviour worked out from the model registers.
    always_comb begin
        own = per_en & per_drive;
        dat = (own & per_out) | (~own & m_lat);
        e_pdrv = ~m_dir & ~m_ans & ~own & IMPL;
        e_oe = (own | e_pdrv) & ~(m_odc & dat) & IMPL;
        e_out = dat & ~m_odc & IMPL;
        e_lvl = (e_oe & e_out) | (~e_oe & ext_oe & ext_val) | (~e_oe & ~ext_oe);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic model_rst();
        m_dir = SPIO_DIR_RST & IMPL;
        m_lat = SPIO_LAT_RST;
        m_odc = SPIO_ODC_RST;
        m_ans = SPIO_ANS_RST & ANA & IMPL;
    endtask : model_rst
    task automatic wr(input spio_sel_e s, input spio_word_t d);
        reg_wr = 1'b1;
        reg_sel = s;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
        case (s)
            SPIO_SEL_DIR: m_dir = d & IMPL;
            SPIO_SEL_ODC: m_odc = d & IMPL;
            SPIO_SEL_ANS: m_ans = d & ANA & IMPL;
            default: m_lat = d & IMPL;
        endcase
        step();
    endtask : wr
    task automatic chk(input logic [2:0] k, input spio_sel_e s, input spio_word_t e);
        reg_sel = s;
        q.push_back('{cyc + 1, k, e});
        step();
    endtask : chk
    task automatic all_chk();
        repeat (5) step();
        chk(3'h1, SPIO_SEL_PIN, e_out);
        chk(3'h2, SPIO_SEL_PIN, e_oe);
        chk(3'h3, SPIO_SEL_PIN, e_lvl & ~(e_pdrv & e_oe) & IMPL);
        chk(3'h0, SPIO_SEL_PIN, e_lvl & IMPL & ~(m_ans & m_dir));
        chk(3'h4, SPIO_SEL_DIR, m_dir);
        chk(3'h0, SPIO_SEL_ODC, m_odc);
        chk(3'h0, SPIO_SEL_ANS, m_ans);
    endtask : all_chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    always @(negedge clk) begin
        if (q.size() > 0 && q[0].at == cyc) begin
            c = q.pop_front();
            case (c.k)
                3'h0: g = reg_rdata;
                3'h1: g = pad_out;
                3'h2: g = pad_oe;
                3'h3: g = per_in;
                3'h4: g = dir_o;
                default: g = lat_o;
            endcase
            n_tests++;
            if (g !== c.e) begin
                miscompares++;
                $display("BAD %0t kind %0d got %h expected %h", $time, c.k, g, c.e);
            end
        end
    end
    initial begin
        #(40 * 5000);
        miscompares++;
        test_done();
    end
    initial begin
        model_rst();
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk(3'h4, SPIO_SEL_DIR, IMPL);
        chk(3'h0, SPIO_SEL_DIR, IMPL);
        chk(3'h0, SPIO_SEL_LAT, 16'h0000);
        chk(3'h0, SPIO_SEL_ANS, ANA & IMPL);
        all_chk();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(i[0] ? SPIO_SEL_PIN : SPIO_SEL_LAT, seed[15:0]);
            chk(3'h0, SPIO_SEL_LAT, m_lat);
            chk(3'h5, SPIO_SEL_LAT, m_lat);
        end
        $display("test latch done");
        wr(SPIO_SEL_ANS, 16'h0000);
        wr(SPIO_SEL_DIR, 16'h00FF);
        all_chk();
        wr(SPIO_SEL_ODC, 16'h0F33);
        all_chk();
        per_en = IMPL;
        all_chk();
        $display("test drive done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            per_drive = seed[15:0] & IMPL;
            per_out = seed[31:16] & IMPL;
            seed = lfsr(seed);
            ext_val = seed[15:0];
            ext_oe = seed[31:16];
            wr(SPIO_SEL_DIR, seed[31:16] ^ seed[15:0]);
            wr(SPIO_SEL_ANS, seed[23:8]);
            wr(SPIO_SEL_ODC, seed[15:0]);
            per_en = seed[27:12] & IMPL;
            all_chk();
        end
        $display("test peripheral done");
        per_en = 16'h0000;
        sys_rst = 1'b1;
        repeat (2) step();
        sys_rst = 1'b0;
        model_rst();
        chk(3'h0, SPIO_SEL_DIR, IMPL);
        all_chk();
        $display("test second reset done");
        repeat (2) step();
        if (q.size() != 0) begin
            miscompares++;
            $display("BAD %0t %0d checks never compared", $time, q.size());
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
